// ---- core/cac_pkg.sv ----
// package: constants, register map and types of the channel alarm comparator
package cac_pkg;
  localparam int CAC_NAL  = 8;
  localparam int CAC_NCO  = 4;
  localparam int CAC_NCH  = 8;
  localparam int CAC_NST  = 4;
  localparam int CAC_NIF  = 8;
  localparam int CAC_NSRC = 2 * CAC_NAL + 2 * CAC_NCO + CAC_NST;

  // register offsets on the plain register port
  localparam logic [7:0] CAC_A_ACTL  = 8'h00;
  localparam logic [7:0] CAC_A_LVL   = 8'h08;
  localparam logic [7:0] CAC_A_HYS   = 8'h10;
  localparam logic [7:0] CAC_A_CTHR  = 8'h18;
  localparam logic [7:0] CAC_A_CPER  = 8'h1C;
  localparam logic [7:0] CAC_A_CMAP  = 8'h20;
  localparam logic [7:0] CAC_A_PWR   = 8'h28;
  localparam logic [7:0] CAC_A_ISTAT = 8'h29;
  localparam logic [7:0] CAC_A_IMASK = 8'h2A;
  localparam logic [7:0] CAC_A_ACT   = 8'h2B;
  localparam logic [7:0] CAC_A_TINC  = 8'h2C;
  localparam logic [7:0] CAC_A_DIN   = 8'h2D;
  localparam logic [7:0] CAC_A_CEN   = 8'h2E;

  // alarm control field positions
  localparam int CAC_F_EN   = 0;
  localparam int CAC_F_KIND = 1;
  localparam int CAC_F_CH   = 4;
  localparam int CAC_F_CH2  = 8;

  // values after reset
  localparam logic [31:0] CAC_WORD_RST  = 32'h0000_0000;
  localparam logic [15:0] CAC_IMASK_RST = 16'h0000;

  typedef enum logic [1:0] {CAC_LOWER, CAC_UPPER, CAC_DIFF_GT, CAC_DIFF_LT} cac_kind_t;
  typedef enum logic [2:0] {CAC_M_ENTER, CAC_M_EXIT, CAC_M_CENTER, CAC_M_CEXIT, CAC_M_STATE} cac_mkind_t;

  typedef struct packed {
    logic               en;
    cac_kind_t          kind;
    logic [2:0]         chan;
    logic [2:0]         chan2;
    logic signed [31:0] level;
    logic signed [31:0] hyst;
  } cac_acfg_t;

  typedef struct packed {
    logic               valid;
    logic [2:0]         chan;
    logic signed [31:0] value;
  } cac_dp_t;

  typedef struct packed {
    logic        en;
    logic [31:0] thr;
    logic [31:0] period;
  } cac_ccfg_t;

  typedef struct packed {
    logic       valid;
    cac_mkind_t kind;
    logic [2:0] index;
    logic       level;
  } cac_msg_t;

  function automatic logic signed [33:0] cac_ext(input logic signed [31:0] v);
    return {{2{v[31]}}, v};
  endfunction
endpackage

// ---- core/cac_alarm.sv ----
// channel alarm evaluator: one limit or difference alarm with hysteresis
module cac_alarm (
  // clock, reset, enable
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  // configuration and datapoint stream
  input  wire cac_pkg::cac_acfg_t cfg,
  input  wire cac_pkg::cac_dp_t   dp,
  // alarm state and entry/exit pulses
  output logic                    active,
  output logic                    enter,
  output logic                    leave
);
  typedef struct packed {
    logic               active;
    logic               enter;
    logic               leave;
    logic signed [31:0] sec;
  } cac_ast_t;

  cac_ast_t           st;
  cac_ast_t           next_st;
  logic               hit;
  logic               set_c;
  logic               rel_c;
  logic signed [33:0] x;
  logic signed [33:0] lvl;
  logic signed [33:0] hy;

  always_comb begin
    next_st       = st;
    next_st.enter = 1'b0;
    next_st.leave = 1'b0;
    hit = dp.valid && cfg.en && (dp.chan == cfg.chan);
    lvl = cac_pkg::cac_ext(cfg.level);
    hy  = cac_pkg::cac_ext(cfg.hyst);
    x   = cac_pkg::cac_ext(dp.value);
    // second channel keeps its latest datapoint
    if (cfg.kind == cac_pkg::CAC_DIFF_GT || cfg.kind == cac_pkg::CAC_DIFF_LT) begin
      x = x - cac_pkg::cac_ext(st.sec);
    end
    set_c = 1'b0;
    rel_c = 1'b0;
    unique case (cfg.kind)
      cac_pkg::CAC_LOWER: begin // [R6] [R7] [R16]
        set_c = x < lvl;
        rel_c = x > lvl + hy;
      end
      cac_pkg::CAC_UPPER: begin // [R8] [R9] [R16]
        set_c = x > lvl;
        rel_c = x < lvl - hy;
      end
      cac_pkg::CAC_DIFF_GT: begin // [R10] [R11]
        set_c = x > lvl;
        rel_c = x < lvl - hy;
      end
      cac_pkg::CAC_DIFF_LT: begin // [R12] [R13]
        set_c = x < lvl;
        rel_c = x > lvl + hy;
      end
    endcase
    if (dp.valid && dp.chan == cfg.chan2) begin
      next_st.sec = dp.value;
    end
    // disabling an active alarm still reports its exit
    if (!cfg.en && st.active) begin
      next_st.active = 1'b0;
      next_st.leave  = 1'b1;
    end else if (hit && !st.active && set_c) begin // [R17]
      next_st.active = 1'b1;
      next_st.enter  = 1'b1;
    end else if (hit && st.active && rel_c) begin
      next_st.active = 1'b0;
      next_st.leave  = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign active = st.active;
  assign enter  = st.enter;
  assign leave  = st.leave;

  a_lower_set: assert property (@(posedge clk) disable iff (rst) // [R6]
    ce && hit && !active && cfg.kind == cac_pkg::CAC_LOWER && x < lvl |=> active && enter)
    else $error("lower alarm did not set");
  a_lower_hold: assert property (@(posedge clk) disable iff (rst) // [R7]
    ce && hit && active && cfg.kind == cac_pkg::CAC_LOWER && x <= lvl + hy |=> active && !leave)
    else $error("lower alarm released inside hysteresis");
  a_upper_rel: assert property (@(posedge clk) disable iff (rst) // [R9]
    ce && hit && active && cfg.kind == cac_pkg::CAC_UPPER && x < lvl - hy |=> !active && leave)
    else $error("upper alarm did not release");
  a_diff_gt: assert property (@(posedge clk) disable iff (rst) // [R10]
    ce && hit && !active && cfg.kind == cac_pkg::CAC_DIFF_GT && x > lvl |=> active)
    else $error("difference alarm did not set");
  a_diff_lt_rel: assert property (@(posedge clk) disable iff (rst) // [R13]
    ce && hit && active && cfg.kind == cac_pkg::CAC_DIFF_LT && x > lvl + hy |=> !active)
    else $error("difference alarm did not release");
  a_hold_between: assert property (@(posedge clk) disable iff (rst) // [R17]
    ce && cfg.en && !hit |=> active == $past(active) && !enter && !leave)
    else $error("alarm changed without a datapoint");
endmodule

// ---- core/cac_cons.sv ----
// consumption alarm: totals a flow input over a period against a threshold
module cac_cons (
  // clock, reset, enable
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  // configuration and flow increments
  input  wire cac_pkg::cac_ccfg_t cfg,
  input  wire logic               inc_valid,
  input  wire logic [15:0]        inc_amt,
  // alarm state and entry/exit pulses
  output logic                    active,
  output logic                    enter,
  output logic                    leave
);
  typedef struct packed {
    logic [31:0] total;
    logic [31:0] timer;
    logic        active;
    logic        enter;
    logic        leave;
  } cac_cst_t;

  cac_cst_t    st;
  cac_cst_t    next_st;
  logic [32:0] sum;
  logic        wrap;

  always_comb begin
    next_st       = st;
    next_st.enter = 1'b0;
    next_st.leave = 1'b0;
    sum  = {1'b0, st.total} + {17'h0_0000, (inc_valid ? inc_amt : 16'h0000)};
    // not an equality: a period shortened below the running count must still end
    wrap = (cfg.period != 32'h0000_0000) && (st.timer >= cfg.period - 32'h0000_0001);
    if (!cfg.en || wrap) begin
      // a new period starts from zero and ends any running alarm
      next_st.total = 32'h0000_0000;
      next_st.timer = 32'h0000_0000;
      if (st.active) begin
        next_st.active = 1'b0;
        next_st.leave  = 1'b1;
      end
    end else begin
      next_st.timer = st.timer + 32'h0000_0001;
      // saturate instead of wrapping, a wrap would hide a big total
      next_st.total = sum[32] ? 32'hFFFF_FFFF : sum[31:0];
      if (!st.active && next_st.total > cfg.thr) begin // [R3]
        next_st.active = 1'b1;
        next_st.enter  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign active = st.active;
  assign enter  = st.enter;
  assign leave  = st.leave;

  a_cons_at_once: assert property (@(posedge clk) disable iff (rst) // [R3]
    ce && cfg.en && !wrap && !active && sum > {1'b0, cfg.thr} |=> active && enter)
    else $error("consumption alarm waited");
  a_cons_period: assert property (@(posedge clk) disable iff (rst) // [R2]
    ce && cfg.en && wrap |=> !active && st.total == 32'h0000_0000)
    else $error("consumption period did not restart");
endmodule

// ---- core/cac_top.sv ----
// channel alarm comparator: alarms, consumption, state events, messages, registers
//
// Summary of operation
// R1: eight independent channel alarms on datapoint streams
// R2: four consumption alarms total flow over period
// R3: consumption alarm sets as soon as exceeded
// R4: each digital input edge is one event
// R5: one message on alarm entry, one on exit
// R6: lower alarm sets when datapoint below level
// R7: lower alarm releases above level plus hysteresis
// R8: upper alarm sets when datapoint above level
// R9: upper alarm releases below level minus hysteresis
// R10: difference greater sets when difference exceeds level
// R11: difference greater releases below level minus hysteresis
// R12: difference less sets when difference below level
// R13: difference less releases above level plus hysteresis
// R14: constant power keeps one sensor, disables others
// R15: test includes interface only when channel uses it
// R16: zero hysteresis releases on recrossing the threshold
// R17: evaluate per new datapoint, hold between them
module cac_top (
  // clock, reset, enable
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    ce,
  // register port
  input  wire logic [7:0]              addr,
  input  wire logic [31:0]             wdata,
  input  wire logic                    wr,
  input  wire logic                    rd,
  output logic [31:0]                  rdata,
  // datapoint stream
  input  wire cac_pkg::cac_dp_t        dp,
  // flow interfaces
  input  wire logic [3:0]              flow_valid,
  input  wire logic [3:0][15:0]        flow_amt,
  // digital inputs
  input  wire logic [3:0]              din,
  // sensor power
  input  wire logic [7:0]              sens_req,
  output logic [7:0]                   sens_pwr,
  // hardware test interface selection
  output logic [7:0]                   test_incl,
  // messages to the remote server
  output cac_pkg::cac_msg_t            msg,
  input  wire logic                    msg_ready,
  // interrupt
  output logic                         irq
);
  typedef struct packed {
    cac_pkg::cac_acfg_t [cac_pkg::CAC_NAL-1:0] acfg;
    cac_pkg::cac_ccfg_t [cac_pkg::CAC_NCO-1:0] ccfg;
    logic [cac_pkg::CAC_NCH-1:0][3:0]          cmap;
    logic [3:0]                                pwr;
    logic [15:0]                               istat;
    logic [15:0]                               imask;
    logic [cac_pkg::CAC_NSRC-1:0]              pend;
    logic [3:0]                                din_q;
    logic                                      primed;
    cac_pkg::cac_msg_t                         msg;
    logic [31:0]                               rdata;
    logic [7:0]                                sens_pwr;
    logic [7:0]                                test_incl;
    logic                                      irq;
  } cac_top_st_t;

  cac_top_st_t                  st;
  cac_top_st_t                  next_st;
  logic [cac_pkg::CAC_NAL-1:0]  al_act;
  logic [cac_pkg::CAC_NAL-1:0]  al_ent;
  logic [cac_pkg::CAC_NAL-1:0]  al_lve;
  logic [cac_pkg::CAC_NCO-1:0]  co_act;
  logic [cac_pkg::CAC_NCO-1:0]  co_ent;
  logic [cac_pkg::CAC_NCO-1:0]  co_lve;
  logic [3:0]                   st_ev;
  logic [15:0]                  ev;
  logic [cac_pkg::CAC_NSRC-1:0] src;
  logic [4:0]                   sel;
  logic [31:0]                  rval;
  logic                         rd_istat;

  function automatic logic [4:0] cac_first(input logic [cac_pkg::CAC_NSRC-1:0] v);
    cac_first = 5'h00;
    for (int i = cac_pkg::CAC_NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        cac_first = 5'(i);
      end
    end
  endfunction

  genvar g;
  for (g = 0; g < cac_pkg::CAC_NAL; g++) begin : g_al
    cac_alarm u_al ( // [R1]
      .clk    (clk),
      .rst    (rst),
      .ce     (ce),
      .cfg    (st.acfg[g]),
      .dp     (dp),
      .active (al_act[g]),
      .enter  (al_ent[g]),
      .leave  (al_lve[g])
    );
  end

  for (g = 0; g < cac_pkg::CAC_NCO; g++) begin : g_co
    cac_cons u_co ( // [R2]
      .clk       (clk),
      .rst       (rst),
      .ce        (ce),
      .cfg       (st.ccfg[g]),
      .inc_valid (flow_valid[g]),
      .inc_amt   (flow_amt[g]),
      .active    (co_act[g]),
      .enter     (co_ent[g]),
      .leave     (co_lve[g])
    );
  end

  // inputs are compared with their last level only after the first sample
  assign st_ev    = st.primed ? (din ^ st.din_q) : 4'h0; // [R4]
  assign ev       = {st_ev, co_ent | co_lve, al_ent | al_lve};
  assign src      = {st_ev, co_lve, co_ent, al_lve, al_ent}; // [R5]
  assign sel      = cac_first(st.pend);
  assign rd_istat = rd && (addr == cac_pkg::CAC_A_ISTAT);

  // read mux
  always_comb begin
    rval = 32'h0000_0000;
    if (addr < cac_pkg::CAC_A_LVL) begin
      rval[cac_pkg::CAC_F_EN]        = st.acfg[addr[2:0]].en;
      rval[cac_pkg::CAC_F_KIND +: 2] = st.acfg[addr[2:0]].kind;
      rval[cac_pkg::CAC_F_CH +: 3]   = st.acfg[addr[2:0]].chan;
      rval[cac_pkg::CAC_F_CH2 +: 3]  = st.acfg[addr[2:0]].chan2;
    end else if (addr < cac_pkg::CAC_A_HYS) begin
      rval = st.acfg[addr[2:0]].level;
    end else if (addr < cac_pkg::CAC_A_CTHR) begin
      rval = st.acfg[addr[2:0]].hyst;
    end else if (addr < cac_pkg::CAC_A_CPER) begin
      rval = st.ccfg[addr[1:0]].thr;
    end else if (addr < cac_pkg::CAC_A_CMAP) begin
      rval = st.ccfg[addr[1:0]].period;
    end else if (addr < cac_pkg::CAC_A_PWR) begin
      rval[3:0] = st.cmap[addr[2:0]];
    end else begin
      unique case (addr)
        cac_pkg::CAC_A_PWR:   rval[3:0] = st.pwr;
        cac_pkg::CAC_A_ISTAT: rval[15:0] = st.istat;
        cac_pkg::CAC_A_IMASK: rval[15:0] = st.imask;
        cac_pkg::CAC_A_ACT:   rval[11:0] = {co_act, al_act};
        cac_pkg::CAC_A_TINC:  rval[7:0] = st.test_incl;
        cac_pkg::CAC_A_DIN:   rval[3:0] = st.din_q;
        cac_pkg::CAC_A_CEN: begin
          for (int i = 0; i < cac_pkg::CAC_NCO; i++) begin
            rval[i] = st.ccfg[i].en;
          end
        end
        default:              rval = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    next_st = st;
    // register writes
    if (wr) begin
      if (addr < cac_pkg::CAC_A_LVL) begin
        next_st.acfg[addr[2:0]].en    = wdata[cac_pkg::CAC_F_EN];
        next_st.acfg[addr[2:0]].kind  = cac_pkg::cac_kind_t'(wdata[cac_pkg::CAC_F_KIND +: 2]);
        next_st.acfg[addr[2:0]].chan  = wdata[cac_pkg::CAC_F_CH +: 3];
        next_st.acfg[addr[2:0]].chan2 = wdata[cac_pkg::CAC_F_CH2 +: 3];
      end else if (addr < cac_pkg::CAC_A_HYS) begin
        next_st.acfg[addr[2:0]].level = wdata;
      end else if (addr < cac_pkg::CAC_A_CTHR) begin
        next_st.acfg[addr[2:0]].hyst = wdata;
      end else if (addr < cac_pkg::CAC_A_CPER) begin
        next_st.ccfg[addr[1:0]].thr = wdata;
      end else if (addr < cac_pkg::CAC_A_CMAP) begin
        next_st.ccfg[addr[1:0]].period = wdata;
      end else if (addr < cac_pkg::CAC_A_PWR) begin
        next_st.cmap[addr[2:0]] = wdata[3:0];
      end else if (addr == cac_pkg::CAC_A_PWR) begin
        next_st.pwr = wdata[3:0];
      end else if (addr == cac_pkg::CAC_A_IMASK) begin
        next_st.imask = wdata[15:0];
      end else if (addr == cac_pkg::CAC_A_CEN) begin
        for (int i = 0; i < cac_pkg::CAC_NCO; i++) begin
          next_st.ccfg[i].en = wdata[i];
        end
      end
    end
    // read data stand one cycle only
    next_st.rdata = rd ? rval : 32'h0000_0000;
    // sticky status: an event in the clearing cycle survives
    next_st.istat = (rd_istat ? 16'h0000 : st.istat) | ev;
    next_st.irq   = |(next_st.istat & next_st.imask);
    // digital input sampling
    next_st.din_q  = din;
    next_st.primed = 1'b1;
    // message slot, refilled when empty or accepted
    if (!st.msg.valid || msg_ready) begin
      next_st.msg.valid = |st.pend;
      next_st.msg.index = (sel < 5'd16) ? sel[2:0] : {1'b0, sel[1:0]};
      next_st.msg.level = 1'b0;
      if (sel < 5'd8) begin
        next_st.msg.kind = cac_pkg::CAC_M_ENTER;
      end else if (sel < 5'd16) begin
        next_st.msg.kind = cac_pkg::CAC_M_EXIT;
      end else if (sel < 5'd20) begin
        next_st.msg.kind = cac_pkg::CAC_M_CENTER;
      end else if (sel < 5'd24) begin
        next_st.msg.kind = cac_pkg::CAC_M_CEXIT;
      end else begin
        next_st.msg.kind  = cac_pkg::CAC_M_STATE;
        next_st.msg.level = st.din_q[sel[1:0]];
      end
      if (|st.pend) begin
        next_st.pend[sel] = 1'b0;
      end
    end
    // new sources are merged after the pick so none is dropped
    next_st.pend = next_st.pend | src; // [R5]
    // constant power overrides the normal sensor power requests
    if (st.pwr[0]) begin // [R14]
      next_st.sens_pwr = 8'h01 << st.pwr[3:1];
    end else begin
      next_st.sens_pwr = sens_req;
    end
    next_st.test_incl = 8'h00;
    for (int i = 0; i < cac_pkg::CAC_NCH; i++) begin
      if (st.cmap[i][0]) begin // [R15]
        next_st.test_incl[st.cmap[i][3:1]] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st       <= '0;
      st.imask <= cac_pkg::CAC_IMASK_RST;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign rdata     = st.rdata;
  assign sens_pwr  = st.sens_pwr;
  assign test_incl = st.test_incl;
  assign msg       = st.msg;
  assign irq       = st.irq;

  a_msg_enter: assert property (@(posedge clk) disable iff (rst) // [R5]
    ce && al_ent[0] |=> st.pend[0])
    else $error("alarm entry not queued");
  a_msg_exit: assert property (@(posedge clk) disable iff (rst) // [R5]
    ce && al_lve[0] |=> st.pend[8])
    else $error("alarm exit not queued");
  a_msg_hold: assert property (@(posedge clk) disable iff (rst) // [R5]
    ce && msg.valid && !msg_ready |=> msg.valid && msg == $past(msg))
    else $error("message changed before acceptance");
  a_state_edge: assert property (@(posedge clk) disable iff (rst) // [R4]
    ce && st.primed && din[0] != st.din_q[0] |=> st.istat[12] && st.pend[24])
    else $error("input edge not reported");
  a_const_pwr: assert property (@(posedge clk) disable iff (rst) // [R14]
    ce && st.pwr[0] |=> $onehot(sens_pwr))
    else $error("constant power not exclusive");
  a_test_incl: assert property (@(posedge clk) disable iff (rst) // [R15]
    ce && st.cmap == '0 |=> test_incl == 8'h00)
    else $error("unused interface included");
endmodule

// ---- tb/cac_srv_model.sv ----
// remote server model: takes messages with random stalls and counts the channel alarm entries and exits
module cac_srv_model (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // message port
  input  wire cac_pkg::cac_msg_t msg,
  output logic                   msg_ready,
  // tallies of channel alarm entries and exits
  output int                     n_enter,
  output int                     n_exit
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 32'h0956;

  // stalls make the device hold a message for several cycles
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      msg_ready <= 1'b0;
      n_enter   <= 0;
      n_exit    <= 0;
    end else begin
      msg_ready <= ($random(seed) % 3) != 0;
      if (msg.valid && msg_ready && msg.kind == cac_pkg::CAC_M_ENTER) n_enter <= n_enter + 1;
      if (msg.valid && msg_ready && msg.kind == cac_pkg::CAC_M_EXIT) n_exit <= n_exit + 1;
    end
  end
endmodule

// ---- tb/channel_alarm_comparator_bench.sv ----
// testbench of the channel alarm comparator
module channel_alarm_comparator_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  cac_pkg::cac_dp_t dp = '0;
  logic [3:0] flow_valid = 4'h0;
  logic [3:0][15:0] flow_amt = '0;
  logic [3:0] din = 4'h0;
  logic [7:0] sens_req = 8'hFF;
  logic [7:0] sens_pwr;
  logic [7:0] test_incl;
  cac_pkg::cac_msg_t msg;
  logic msg_ready;
  logic irq;
  int n_enter;
  int n_exit;
  int errors = 0;
  int n_checks = 0;
  int seed = 32'h0956;
  int exp_en = 0;
  int exp_ex = 0;
  logic [3:0] exp_act = 4'h0;
  logic [31:0] r;

  always #5 clk = ~clk;

  cac_top i_cac_top (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .dp(dp), .flow_valid(flow_valid), .flow_amt(flow_amt), .din(din), .sens_req(sens_req),
    .sens_pwr(sens_pwr), .test_incl(test_incl), .msg(msg), .msg_ready(msg_ready), .irq(irq));
  cac_srv_model i_cac_srv_model (.clk(clk), .rst(rst), .msg(msg), .msg_ready(msg_ready),
    .n_enter(n_enter), .n_exit(n_exit));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task finish_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) begin
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
    end
    @(posedge clk) wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk) begin
      addr <= a;
      rd   <= 1'b1;
    end
    @(posedge clk) rd <= 1'b0;
    #1 d = rdata;
  endtask

  task send_dp(input logic [2:0] ch, input int v);
    @(posedge clk) dp <= '{1'b1, ch, 32'(v)};
    @(posedge clk) dp.valid <= 1'b0;
  endtask

  // next alarm state; difference kinds get x already reduced by the second channel
  function automatic logic nxt(input int k, input logic a, input int x, input int l, input int h);
    if (k == 0 || k == 3) return a ? !(x > l + h) : (x < l);
    return a ? !(x < l - h) : (x > l);
  endfunction

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_reg(cac_pkg::CAC_A_IMASK, r); chk(r, 32'(cac_pkg::CAC_IMASK_RST));
    rd_reg(8'hFF, r); chk(r, 32'h0);
    // alarm k: kind k on channel k, second channel 7, level 10, alarm 0 without hysteresis
    for (int k = 0; k < 4; k++) begin
      wr_reg(cac_pkg::CAC_A_LVL + 8'(k), 32'h0000_000A);
      wr_reg(cac_pkg::CAC_A_HYS + 8'(k), (k == 0) ? 32'h0 : 32'h0000_0008);
      wr_reg(cac_pkg::CAC_A_ACTL + 8'(k), 32'h0000_0701 | 32'(k << 1) | 32'(k << 4));
    end
    // second channel is captured only once an alarm points at it
    send_dp(3'h7, 5);
    for (int i = 0; i < 240; i++) begin
      int k;
      int v;
      logic n;
      k = i % 4;
      v = (i < 8) ? ((i % 2) ? 10 : 18) : $random(seed) % 40;
      n = nxt(k, exp_act[k], (k >= 2) ? v - 5 : v, 10, (k == 0) ? 0 : 8);
      if (n && !exp_act[k]) exp_en++;
      if (!n && exp_act[k]) exp_ex++;
      exp_act[k] = n;
      send_dp(3'(k), v);
      repeat (2) @(posedge clk);
      rd_reg(cac_pkg::CAC_A_ACT, r); chk({28'h0, r[3:0]}, {28'h0, exp_act});
    end
    chk(32'(irq), 32'h0);
    wr_reg(cac_pkg::CAC_A_IMASK, 32'h0000_FFFF);
    @(posedge clk);
    #1 chk(32'(irq), 32'h1);
    rd_reg(cac_pkg::CAC_A_ISTAT, r);
    repeat (2) @(posedge clk);
    #1 chk(32'(irq), 32'h0);
    for (int t = 0; t < 400 && (msg.valid !== 1'b0); t++) begin
      @(posedge clk);
      #1;
    end
    chk(32'(msg.valid), 32'h0);
    if (msg.valid !== 1'b0) finish_test();
    chk(32'(n_enter), 32'(exp_en));
    chk(32'(n_exit), 32'(exp_ex));
    // consumption alarm 0: threshold 100, no period restart
    wr_reg(cac_pkg::CAC_A_CTHR, 32'd100);
    wr_reg(cac_pkg::CAC_A_CEN, 32'h1);
    for (int j = 0; j < 2; j++) begin
      @(posedge clk) begin
        flow_valid <= 4'h1;
        flow_amt[0] <= 16'd60;
      end
      @(posedge clk) flow_valid <= 4'h0;
      rd_reg(cac_pkg::CAC_A_ACT, r); chk(32'(r[8]), 32'(j));
    end
    // a shorter period ends the running one at once
    wr_reg(cac_pkg::CAC_A_CPER, 32'h0000_0008);
    rd_reg(cac_pkg::CAC_A_ACT, r); chk(32'(r[8]), 32'h0);
    rd_reg(cac_pkg::CAC_A_ISTAT, r);
    @(posedge clk) din <= 4'h1;
    repeat (3) @(posedge clk);
    rd_reg(cac_pkg::CAC_A_ISTAT, r); chk({28'h0, r[15:12]}, 32'h1);
    rd_reg(cac_pkg::CAC_A_ISTAT, r); chk({28'h0, r[15:12]}, 32'h0);
    wr_reg(cac_pkg::CAC_A_PWR, 32'h5);
    repeat (2) @(posedge clk);
    #1 chk({24'h0, sens_pwr}, 32'h04);
    wr_reg(cac_pkg::CAC_A_PWR, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk({24'h0, sens_pwr}, 32'hFF);
    // a write while frozen must be lost
    @(posedge clk) ce <= 1'b0;
    wr_reg(cac_pkg::CAC_A_PWR, 32'h5);
    @(posedge clk) ce <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk({24'h0, sens_pwr}, 32'hFF);
    chk({24'h0, test_incl}, 32'h0);
    wr_reg(cac_pkg::CAC_A_CMAP, 32'h7);
    repeat (2) @(posedge clk);
    #1 chk({24'h0, test_incl}, 32'h08);
    finish_test();
  end
endmodule
